// *** src/pwmos_top.sv ***
// Functional notes
// - Dead time not shorter than duty keeps the odd output inactive all period.
// - Independent-select bit set gives independent pair, cleared gives complementary.
// - Independent pairs get no dead time; both outputs may be active.
// - Independent: duty 0 drives outs 1/0, duty 1 outs 3/2, duty 2 outs 5/4.
// - Count mode 01 selects single pulse, edge-aligned only.
// - Single pulse: enabled outputs go active when run is set.
// - Single pulse: output goes inactive when count matches its duty.
// - Single pulse period match: clear count, outputs off, clear run, interrupt.
// - Period and duty stay unchanged; setting run again gives another pulse.
// - Override-select set: comparator drives pin; cleared: manual level drives it.
// - Overridden output is active when its manual level bit is set.
// - Complementary: even output overridden active carries complement of odd.
// - Sync bit set defers override changes to a time base sync point.
// - Edge-aligned: sync point is count equal to zero.
// - Center-aligned: sync points are count zero and count equal period.
// - Complementary: even never active while odd active; dead time between.
// - Dead time still inserted while complementary outputs are overridden.
// - Complementary: even override bits have no effect.
// - Odd turning active: even off first, one dead time, then odd on.
// - Odd turning inactive: odd off at once, one dead time, then even on.
// - Each pair has a six-bit down counter loaded on a comparator edge.
// - Prescale 11,10,01,00 select oscillator divided by 16, 8, 4, 2.
// - Dead time equals count divided by prescaled dead-time clock.
// - All pairs reset to complementary mode.
`timescale 1ns/10ps
`default_nettype none
module pwmos_top
  import pwmos_pkg::*;
#(
  parameter int CNT_W = PWMOS_CNT_W,
  parameter int DT_W  = PWMOS_DT_W
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [2:0]       pair_independent_select_in,
  input  wire logic [1:0]       timebase_count_mode_in,
  input  wire logic             timebase_run_set_in,
  input  wire logic             timebase_run_clear_in,
  input  wire logic [CNT_W-1:0] timebase_count_in,
  input  wire logic             timebase_count_down_in,
  input  wire logic [CNT_W-1:0] period_value_in,
  input  wire logic [CNT_W-1:0] duty_value_0_in,
  input  wire logic [CNT_W-1:0] duty_value_1_in,
  input  wire logic [CNT_W-1:0] duty_value_2_in,
  input  wire logic [5:0]       override_select_in,
  input  wire logic [5:0]       manual_level_in,
  input  wire logic             override_write_in,
  input  wire logic             override_sync_enable_in,
  input  wire logic [1:0]       deadtime_prescale_in,
  input  wire logic [DT_W-1:0]  deadtime_count_in,
  input  wire logic             deadtime_write_in,
  input  wire logic             pulse_irq_enable_in,
  input  wire logic             pulse_done_clear_in,
  output logic                  timebase_run_out,
  output logic                  timebase_count_clear_out,
  output logic                  pulse_irq_out,
  output logic                  pulse_done_flag_out,
  output logic [5:0]            override_select_out,
  output logic [5:0]            manual_level_out,
  output logic [5:0]            out_active_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    PWMOS_SP_IDLE  = 3'h1,
    PWMOS_SP_PULSE = 3'h2,
    PWMOS_SP_DONE  = 3'h4
  } pwmos_sp_t;

  pwmos_sp_t              sp_state_ff;
  pwmos_sp_t              nxt_sp_state;
  logic                   run_ff;
  logic                   clr_ff;
  logic                   irq_ff;
  logic                   flag_ff;
  logic [2:0]             indep_ff;
  logic [5:0]             ovr_sel_ff;
  logic [5:0]             man_lvl_ff;
  logic [5:0]             pend_sel_ff;
  logic [5:0]             pend_lvl_ff;
  logic                   pend_ff;
  logic [2:0]             sp_drive_ff;
  logic [3:0]             pre_ff;
  logic [5:0]             out_ff;
  logic [5:0]             nxt_out;
  logic [2:0]             cmp;
  logic [2:0]             odd_drive;
  logic [2:0]             dt_hi;
  logic [2:0]             dt_lo;
  logic [2:0]             dt_load;
  logic [CNT_W-1:0]       duty [PWMOS_NUM_PAIRS];

  ////////////////////////////////////////////////////////////////////////
  // Time base state decode
  wire single_mode = timebase_count_mode_in == PWMOS_MODE_SINGLE;
  wire center_mode = timebase_count_mode_in[1];
  wire cnt_zero    = timebase_count_in == '0;
  wire per_match   = timebase_count_in == period_value_in;
  wire sync_point  = cnt_zero || (center_mode && per_match);
  wire sp_start    = single_mode && timebase_run_set_in && !run_ff;
  wire sp_end      = (sp_state_ff == PWMOS_SP_PULSE) && per_match;

  assign duty[0] = duty_value_0_in;
  assign duty[1] = duty_value_1_in;
  assign duty[2] = duty_value_2_in;

  // Comparator for each pair
  function automatic logic pwmos_compare(input logic [CNT_W-1:0] d,
                                         input logic [CNT_W-1:0] c,
                                         input logic [CNT_W-1:0] p,
                                         input logic             ctr);
    if (d == '0) begin
      pwmos_compare = 1'b0;
    end else if (ctr ? (d >= p) : (d > p)) begin
      pwmos_compare = 1'b1;
    end else begin
      pwmos_compare = c < d;
    end
  endfunction : pwmos_compare

  always_comb begin
    for (int i = 0; i < PWMOS_NUM_PAIRS; i++) begin
      cmp[i] = pwmos_compare(duty[i], timebase_count_in, period_value_in, center_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-pulse sequencer
  always_comb begin
    nxt_sp_state = sp_state_ff;
    unique case (sp_state_ff)
      PWMOS_SP_IDLE:  if (sp_start) nxt_sp_state = PWMOS_SP_PULSE;
      PWMOS_SP_PULSE: begin
        if (sp_end) nxt_sp_state = PWMOS_SP_DONE;
        else if (timebase_run_clear_in || !single_mode) nxt_sp_state = PWMOS_SP_IDLE;
      end
      PWMOS_SP_DONE:  nxt_sp_state = PWMOS_SP_IDLE;
      default:        nxt_sp_state = PWMOS_SP_IDLE;
    endcase
  end

  wire nxt_run  = sp_end ? 1'b0 :
                  timebase_run_set_in ? 1'b1 :
                  timebase_run_clear_in ? 1'b0 : run_ff;
  wire nxt_flag = sp_end || (flag_ff && !pulse_done_clear_in);

  // Per-pair drive during a single pulse: high from start until duty match
  wire [2:0] duty_hit = {timebase_count_in == duty[2],
                         timebase_count_in == duty[1],
                         timebase_count_in == duty[0]};
  wire [2:0] nxt_sp_drive = sp_start ? 3'h7 :
                            (sp_state_ff == PWMOS_SP_PULSE && !sp_end) ?
                            (sp_drive_ff & ~duty_hit) : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Override staging: immediate, or held until a sync point
  wire       take_now  = override_write_in && !override_sync_enable_in;
  wire       take_pend = pend_ff && sync_point && override_sync_enable_in;
  wire [5:0] nxt_sel   = take_now ? override_select_in :
                         take_pend ? pend_sel_ff : ovr_sel_ff;
  wire [5:0] nxt_lvl   = take_now ? manual_level_in :
                         take_pend ? pend_lvl_ff : man_lvl_ff;
  wire       stage     = override_write_in && override_sync_enable_in;
  wire       nxt_pend  = stage || (pend_ff && !take_pend && override_sync_enable_in);

  ////////////////////////////////////////////////////////////////////////
  // Dead-time clock prescaler, cleared on counter load or config write
  wire       pre_clr  = deadtime_write_in || (dt_load != 3'h0);
  wire       dt_tick  = pre_ff == pwmos_pre_max(deadtime_prescale_in);
  wire [3:0] nxt_pre  = (pre_clr || dt_tick) ? 4'h0 : pre_ff + 4'h1;

  ////////////////////////////////////////////////////////////////////////
  // Output selection per pair
  wire [2:0] pair_src = single_mode ? sp_drive_ff : cmp;

  always_comb begin
    for (int i = 0; i < PWMOS_NUM_PAIRS; i++) begin
      // Odd override chooses source for the complementary generator
      odd_drive[i] = ovr_sel_ff[2*i+1] ? pair_src[i] : man_lvl_ff[2*i+1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < PWMOS_NUM_PAIRS; g++) begin : g_pair
      pwmos_deadtime #(
        .DT_W (DT_W)
      ) u_dt (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .drive_in    (odd_drive[g]),
        .dt_tick_in  (dt_tick),
        .dt_count_in (deadtime_count_in),
        .load_out    (dt_load[g]),
        .hi_out      (dt_hi[g]),
        .lo_out      (dt_lo[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_out = 6'h00;
    for (int i = 0; i < PWMOS_NUM_PAIRS; i++) begin
      if (indep_ff[i]) begin
        // One comparator feeds both pins, no dead time
        nxt_out[2*i+1] = ovr_sel_ff[2*i+1] ? pair_src[i] : man_lvl_ff[2*i+1];
        nxt_out[2*i]   = ovr_sel_ff[2*i]   ? pair_src[i] : man_lvl_ff[2*i];
      end else begin
        // Even pin follows the complement of odd, held off outside a single pulse when odd selects the comparator; even override ignored
        nxt_out[2*i+1] = dt_hi[i];
        nxt_out[2*i]   = dt_lo[i] && !(single_mode && sp_state_ff != PWMOS_SP_PULSE &&
                                       ovr_sel_ff[2*i+1]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-pulse state and drive
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sp_state_ff <= PWMOS_SP_IDLE;
      sp_drive_ff <= 3'h0;
    end else begin
      sp_state_ff <= nxt_sp_state;
      sp_drive_ff <= nxt_sp_drive;
    end
  end

  // Run bit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  // End-of-pulse events and sticky flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clr_ff  <= 1'b0;
      irq_ff  <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      clr_ff  <= sp_end;
      irq_ff  <= sp_end && pulse_irq_enable_in;
      flag_ff <= nxt_flag;
    end
  end

  // Pair mode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      indep_ff <= PWMOS_RST_INDEP;
    end else begin
      indep_ff <= pair_independent_select_in;
    end
  end

  // Effective and staged override values
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ovr_sel_ff  <= PWMOS_RST_OVR_SEL;
      man_lvl_ff  <= PWMOS_RST_MAN_LVL;
      pend_sel_ff <= PWMOS_RST_OVR_SEL;
      pend_lvl_ff <= PWMOS_RST_MAN_LVL;
      pend_ff     <= 1'b0;
    end else begin
      ovr_sel_ff  <= nxt_sel;
      man_lvl_ff  <= nxt_lvl;
      pend_sel_ff <= stage ? override_select_in : pend_sel_ff;
      pend_lvl_ff <= stage ? manual_level_in : pend_lvl_ff;
      pend_ff     <= nxt_pend;
    end
  end

  // Dead-time prescaler
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // Output register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_ff <= 6'h00;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign timebase_run_out         = run_ff;
  assign timebase_count_clear_out = clr_ff;
  assign pulse_irq_out            = irq_ff;
  assign pulse_done_flag_out      = flag_ff;
  assign override_select_out      = ovr_sel_ff;
  assign manual_level_out         = man_lvl_ff;
  assign out_active_out           = out_ff;
endmodule : pwmos_top
`default_nettype wire

// *** src/pwmos_pkg.sv ***
package pwmos_pkg;
  localparam int          PWMOS_NUM_PAIRS      = 3;
  localparam int          PWMOS_NUM_OUTS       = 6;
  localparam int          PWMOS_DT_W           = 6;
  localparam int          PWMOS_CNT_W          = 14;
  localparam logic [1:0]  PWMOS_MODE_FREE      = 2'h0;
  localparam logic [1:0]  PWMOS_MODE_SINGLE    = 2'h1;
  localparam logic [1:0]  PWMOS_MODE_UPDN      = 2'h2;
  localparam logic [1:0]  PWMOS_MODE_UPDN_DBL  = 2'h3;
  localparam logic [1:0]  PWMOS_DTPS_DIV2      = 2'h0;
  localparam logic [1:0]  PWMOS_DTPS_DIV4      = 2'h1;
  localparam logic [1:0]  PWMOS_DTPS_DIV8      = 2'h2;
  localparam logic [1:0]  PWMOS_DTPS_DIV16     = 2'h3;
  localparam logic [3:0]  PWMOS_PRE_MAX_DIV2   = 4'h1;
  localparam logic [3:0]  PWMOS_PRE_MAX_DIV4   = 4'h3;
  localparam logic [3:0]  PWMOS_PRE_MAX_DIV8   = 4'h7;
  localparam logic [3:0]  PWMOS_PRE_MAX_DIV16  = 4'hf;
  localparam logic [2:0]  PWMOS_RST_INDEP      = 3'h0;
  localparam logic [5:0]  PWMOS_RST_OVR_SEL    = 6'h3f;
  localparam logic [5:0]  PWMOS_RST_MAN_LVL    = 6'h00;

  // Prescaler terminal count per dead-time clock divide setting
  function automatic logic [3:0] pwmos_pre_max(input logic [1:0] sel);
    unique case (sel)
      PWMOS_DTPS_DIV2:  pwmos_pre_max = PWMOS_PRE_MAX_DIV2;
      PWMOS_DTPS_DIV4:  pwmos_pre_max = PWMOS_PRE_MAX_DIV4;
      PWMOS_DTPS_DIV8:  pwmos_pre_max = PWMOS_PRE_MAX_DIV8;
      PWMOS_DTPS_DIV16: pwmos_pre_max = PWMOS_PRE_MAX_DIV16;
    endcase
  endfunction : pwmos_pre_max
endpackage : pwmos_pkg

// *** src/pwmos_deadtime.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwmos_deadtime
  import pwmos_pkg::*;
#(
  parameter int DT_W = PWMOS_DT_W
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            drive_in,
  input  wire logic            dt_tick_in,
  input  wire logic [DT_W-1:0] dt_count_in,
  output logic                 load_out,
  output logic                 hi_out,
  output logic                 lo_out
);
  logic            drive_ff;
  logic [DT_W-1:0] cnt_ff;
  logic [DT_W-1:0] nxt_cnt;
  wire             edge_seen = drive_in != drive_ff;
  wire             busy      = cnt_ff != '0;

  // Edge reloads the down counter; the opposite turn-on waits for zero
  assign nxt_cnt  = edge_seen ? dt_count_in :
                    (busy && dt_tick_in) ? cnt_ff - 1'b1 : cnt_ff;
  assign load_out = edge_seen;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_ff <= 1'b0;
      cnt_ff   <= '0;
    end else begin
      drive_ff <= drive_in;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Both off while counting; a pulse no longer than the dead time never shows
  assign hi_out = drive_ff && !busy && !edge_seen;
  assign lo_out = !drive_ff && !busy && !edge_seen;
endmodule : pwmos_deadtime
`default_nettype wire

// *** tb/pwmos_top_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwmos_top_chk
  import pwmos_pkg::*;
#(
  parameter int CNT_W = PWMOS_CNT_W
) (
  input wire logic             clk_in,
  input wire logic             rst_in,
  input wire logic [2:0]       pair_independent_select_in,
  input wire logic [1:0]       timebase_count_mode_in,
  input wire logic             timebase_run_set_in,
  input wire logic             timebase_run_clear_in,
  input wire logic [CNT_W-1:0] timebase_count_in,
  input wire logic [CNT_W-1:0] period_value_in,
  input wire logic [5:0]       override_select_in,
  input wire logic [5:0]       manual_level_in,
  input wire logic             override_write_in,
  input wire logic             override_sync_enable_in,
  input wire logic             pulse_irq_enable_in,
  input wire logic             pulse_done_clear_in,
  input wire logic             timebase_run_out,
  input wire logic             timebase_count_clear_out,
  input wire logic             pulse_irq_out,
  input wire logic             pulse_done_flag_out,
  input wire logic [5:0]       override_select_out,
  input wire logic [5:0]       manual_level_out,
  input wire logic [5:0]       out_active_out
);
  logic [2:0] h1_ff, h2_ff, h3_ff;
  wire logic [2:0] comp_w;
  // A pair counts as complementary only once its select has settled
  assign comp_w = ~(pair_independent_select_in | h1_ff | h2_ff | h3_ff);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      h1_ff <= '1;
      h2_ff <= '1;
      h3_ff <= '1;
    end else begin
      h1_ff <= pair_independent_select_in;
      h2_ff <= h1_ff;
      h3_ff <= h2_ff;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_single_end;
    timebase_run_out && timebase_count_mode_in == PWMOS_MODE_SINGLE
      && timebase_count_in == period_value_in;
  endsequence
  sequence s_odd_rise;
    !out_active_out[1] ##1 out_active_out[1] && comp_w[0];
  endsequence
  sequence s_even_rise;
    !out_active_out[0] ##1 out_active_out[0] && comp_w[0];
  endsequence
  a_run_start: assert property (!timebase_run_out && timebase_run_set_in
    && !timebase_run_clear_in |=> timebase_run_out) else $error("run did not start");
  a_run_stop: assert property (timebase_run_clear_in && !timebase_run_set_in
    |=> !timebase_run_out) else $error("run did not stop");
  a_pulse_end: assert property (s_single_end |=> !timebase_run_out
    && timebase_count_clear_out && pulse_done_flag_out) else $error("pulse end wrong");
  a_clear_once: assert property (timebase_count_clear_out |=> !timebase_count_clear_out)
    else $error("count clear too long");
  a_irq_gate: assert property (s_single_end |=> pulse_irq_out == $past(pulse_irq_enable_in))
    else $error("irq gating wrong");
  a_irq_only: assert property (pulse_irq_out |-> timebase_count_clear_out)
    else $error("stray irq");
  a_flag_hold: assert property (pulse_done_flag_out && !pulse_done_clear_in
    |=> pulse_done_flag_out) else $error("flag lost");
  a_ovr_direct: assert property (override_write_in && !override_sync_enable_in
    |=> override_select_out == $past(override_select_in)
    && manual_level_out == $past(manual_level_in)) else $error("override not taken");
  a_ovr_defer: assert property (override_sync_enable_in && timebase_count_in != '0
    && timebase_count_in != period_value_in |=> $stable(override_select_out)
    && $stable(manual_level_out)) else $error("override not deferred");
  a_no_overlap: assert property (!(|(comp_w & {out_active_out[5], out_active_out[3],
    out_active_out[1]} & {out_active_out[4], out_active_out[2], out_active_out[0]})))
    else $error("pair overlap");
  a_odd_gap: assert property (s_odd_rise |-> !$past(out_active_out[0]))
    else $error("odd on without gap");
  a_even_gap: assert property (s_even_rise |-> !$past(out_active_out[1]))
    else $error("even on without gap");
endmodule : pwmos_top_chk
bind pwmos_top pwmos_top_chk #(.CNT_W(CNT_W)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .pair_independent_select_in(pair_independent_select_in),
  .timebase_count_mode_in(timebase_count_mode_in), .timebase_run_set_in(timebase_run_set_in),
  .timebase_run_clear_in(timebase_run_clear_in), .timebase_count_in(timebase_count_in),
  .period_value_in(period_value_in), .override_select_in(override_select_in),
  .manual_level_in(manual_level_in), .override_write_in(override_write_in),
  .override_sync_enable_in(override_sync_enable_in), .pulse_irq_enable_in(pulse_irq_enable_in),
  .pulse_done_clear_in(pulse_done_clear_in), .timebase_run_out(timebase_run_out),
  .timebase_count_clear_out(timebase_count_clear_out), .pulse_irq_out(pulse_irq_out),
  .pulse_done_flag_out(pulse_done_flag_out), .override_select_out(override_select_out),
  .manual_level_out(manual_level_out), .out_active_out(out_active_out));
`default_nettype wire

// *** tb/pwmos_bridge_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwmos_bridge_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] leg_mode_in,
  input  wire logic [5:0] gate_in,
  output logic [7:0]      shoot_cnt_out
);
  logic [2:0] m1_ff, m2_ff, m3_ff;
  // Counts cycles where a settled complementary half-bridge leg conducts top and bottom together
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      m1_ff         <= '1;
      m2_ff         <= '1;
      m3_ff         <= '1;
      shoot_cnt_out <= '0;
    end else begin
      m1_ff <= leg_mode_in;
      m2_ff <= m1_ff;
      m3_ff <= m2_ff;
      for (int i = 0; i < 3; i++) begin
        if (gate_in[2*i] && gate_in[2*i+1] &&
            !(leg_mode_in[i] | m1_ff[i] | m2_ff[i] | m3_ff[i])) begin
          shoot_cnt_out <= shoot_cnt_out + 8'h01;
        end
      end
    end
  end
endmodule : pwmos_bridge_model
`default_nettype wire

// *** tb/pwm_output_stage_override_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwm_output_stage_override_bench;
  import pwmos_pkg::*;
  localparam int W = PWMOS_CNT_W;
  logic         clk_in, rst_in, run_set, run_clr, ovr_wr, ovr_sync, dt_wr, irq_en, done_clr;
  logic         run_o, clr_o, irq_o, flag_o;
  logic [1:0]   mode, dtps;
  logic [2:0]   indep;
  logic [5:0]   osel, oman, osel_o, oman_o, act, dtc;
  logic [W-1:0] cnt, per, d0, d1, d2;
  logic [7:0]   shoot;
  int           cmode, error_cnt, check_count, g, hi, irqs;
  pwmos_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .pair_independent_select_in(indep),
    .timebase_count_mode_in(mode), .timebase_run_set_in(run_set), .timebase_run_clear_in(run_clr),
    .timebase_count_in(cnt), .timebase_count_down_in(1'b0), .period_value_in(per),
    .duty_value_0_in(d0), .duty_value_1_in(d1), .duty_value_2_in(d2), .override_select_in(osel),
    .manual_level_in(oman), .override_write_in(ovr_wr), .override_sync_enable_in(ovr_sync),
    .deadtime_prescale_in(dtps), .deadtime_count_in(dtc), .deadtime_write_in(dt_wr),
    .pulse_irq_enable_in(irq_en), .pulse_done_clear_in(done_clr), .timebase_run_out(run_o),
    .timebase_count_clear_out(clr_o), .pulse_irq_out(irq_o), .pulse_done_flag_out(flag_o),
    .override_select_out(osel_o), .manual_level_out(oman_o), .out_active_out(act));
  pwmos_bridge_model u_load (.clk_in(clk_in), .rst_in(rst_in), .leg_mode_in(indep),
    .gate_in(act), .shoot_cnt_out(shoot));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Time base stand-in: hold, free run, or single pulse counting
  always @(posedge clk_in)
    if (clr_o) cnt <= '0;
    else if (cmode == 1) cnt <= (cnt == per) ? '0 : cnt + 1'b1;
    else if (cmode == 2 && run_o && cnt != per) cnt <= cnt + 1'b1;
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ovr(input logic [5:0] s, input logic [5:0] m);
    tick(1);
    osel   <= s;
    oman   <= m;
    ovr_wr <= 1'b1;
    tick(1);
    ovr_wr <= 1'b0;
  endtask : ovr
  task automatic setdt(input logic [1:0] p, input logic [5:0] v);
    tick(1);
    dtps  <= p;
    dtc   <= v;
    dt_wr <= 1'b1;
    tick(1);
    dt_wr <= 1'b0;
  endtask : setdt
  task automatic gap(input int a, input int b, output int n);
    n = 0;
    #1;
    while (act[a] === 1'b1 && n < 300) begin
      tick(1);
      #1;
      n++;
    end
    n = 0;
    while (act[b] !== 1'b1 && n < 300) begin
      tick(1);
      #1;
      n++;
    end
  endtask : gap
  function automatic logic [5:0] exp_out(input logic [2:0] ind, input logic [W-1:0] c);
    logic [5:0] r;
    logic [W-1:0] d [3];
    logic cm;
    d = '{d0, d1, d2};
    for (int i = 0; i < 3; i++) begin
      cm = c < d[i];
      r[2*i+1] = osel[2*i+1] ? cm : oman[2*i+1];
      r[2*i] = ind[i] ? (osel[2*i] ? cm : oman[2*i]) : !r[2*i+1];
    end
    return r;
  endfunction : exp_out
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    #(50 * 30000);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst_in, run_set, run_clr, ovr_wr, ovr_sync, dt_wr, irq_en, done_clr} = 8'h80;
    {mode, dtps, indep, osel, oman, dtc, cnt, per, d0, d1, d2} = '0;
    {cmode, error_cnt, check_count} = '0;
    void'($urandom(75683));
    tick(8);
    rst_in <= 1'b0;
    run_clr <= 1'b1;
    tick(1);
    run_clr <= 1'b0;
    ovr(6'h00, 6'h03);
    tick(8);
    #1;
    chk(16'(act[1:0]), 16'h2);
    $display("test 1 done");
    setdt(2'h0, 6'h02);
    for (int k = 0; k < 16; k++) begin
      tick(1);
      indep <= 3'($urandom);
      per <= W'(100);
      d0 <= (k < 2) ? W'(k * 101) : W'($urandom_range(0, 110));
      d1 <= W'($urandom_range(0, 110));
      d2 <= W'($urandom_range(0, 110));
      cnt <= W'($urandom_range(0, 100));
      ovr(6'($urandom), 6'($urandom));
      tick(24);
      #1;
      chk(16'(act), 16'(exp_out(indep, cnt)));
    end
    $display("test 2 done");
    tick(1);
    indep <= 3'h0;
    for (int p = 0; p < 4; p++) begin
      setdt(2'(p), 6'h03);
      ovr(6'h00, 6'h00);
      tick(60);
      ovr(6'h00, 6'h02);
      gap(0, 1, g);
      chk(16'(g >= 3 * (2 << p) - 1 && g <= 3 * (2 << p) + 3), 16'h1);
      ovr(6'h00, 6'h00);
      gap(1, 0, g);
      chk(16'(g >= 3 * (2 << p) - 1 && g <= 3 * (2 << p) + 3), 16'h1);
    end
    $display("test 3 done");
    setdt(2'h3, 6'h03);
    ovr(6'h3f, 6'h00);
    d0 <= W'(2);
    per <= W'(30);
    cnt <= '0;
    cmode <= 1;
    hi = 0;
    for (int k = 0; k < 100; k++) begin
      tick(1);
      #1;
      hi += int'(act[1:0] !== 2'h0);
    end
    chk(16'(hi), 16'h0);
    $display("test 4 done");
    cmode <= 0;
    tick(1);
    per <= W'(40);
    cnt <= W'(5);
    ovr_sync <= 1'b1;
    ovr(6'h15, 6'h2a);
    tick(3);
    #1;
    chk(16'(osel_o), 16'h3f);
    tick(1);
    cnt <= '0;
    tick(3);
    #1;
    chk(16'(osel_o), 16'h15);
    chk(16'(oman_o), 16'h2a);
    tick(1);
    mode <= PWMOS_MODE_UPDN;
    cnt <= W'(5);
    ovr(6'h3f, 6'h00);
    tick(3);
    #1;
    chk(16'(osel_o), 16'h15);
    tick(1);
    cnt <= per;
    tick(3);
    #1;
    chk(16'(osel_o), 16'h3f);
    $display("test 5 done");
    tick(1);
    ovr_sync <= 1'b0;
    setdt(2'h0, 6'h02);
    indep <= 3'h7;
    mode <= PWMOS_MODE_SINGLE;
    d0 <= W'(12);
    per <= W'(30);
    cnt <= '0;
    cmode <= 2;
    for (int e = 0; e < 2; e++) begin
      tick(4);
      irq_en <= 1'(e);
      run_set <= 1'b1;
      tick(1);
      run_set <= 1'b0;
      {hi, irqs} = '0;
      for (int k = 0; k < 40; k++) begin
        tick(1);
        #1;
        hi += int'(act[1] === 1'b1);
        irqs += int'(irq_o === 1'b1);
      end
      chk(16'(hi >= 11 && hi <= 14), 16'h1);
      chk({15'h0, run_o}, 16'h0);
      chk(16'(irqs), 16'(e));
      chk({15'h0, flag_o}, 16'h1);
      tick(1);
      done_clr <= 1'b1;
      tick(1);
      done_clr <= 1'b0;
      tick(1);
      #1;
      chk({15'h0, flag_o}, 16'h0);
    end
    chk(16'(shoot), 16'h0);
    $display("test 6 done");
    wrap_up();
  end
endmodule : pwm_output_stage_override_bench
`default_nettype wire
